// ---- rtl/dmsl_pkg.sv ----
// package for the multiply-step and logic-op datapath
// assumes a single pclk domain and an apb master for register access
package dmsl_pkg;
  // byte offsets of the apb registers
  localparam logic [7:0] OFF_ACC_HI = 8'h00; // upper accumulator
  localparam logic [7:0] OFF_ACC_LO = 8'h04; // lower accumulator
  localparam logic [7:0] OFF_OPND = 8'h08; // multiplier operand
  localparam logic [7:0] OFF_FLAGS = 8'h0c; // condition flags
  localparam logic [7:0] OFF_CMD = 8'h10; // instruction issue
  // command field layout
  localparam int CMD_OP_LSB = 0; // opcode bits 1:0
  localparam int CMD_SEL1_LSB = 4; // first accumulator select 5:4
  localparam int CMD_SEL2_LSB = 8; // second accumulator select 9:8
  // flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_O = 1;
  localparam int FLG_S = 2;
  localparam int FLG_Z = 3;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  // opcodes
  typedef enum logic [1:0] {
    OP_NOP = 2'h0,
    OP_MULT = 2'h1,
    OP_NOT = 2'h2,
    OP_OR = 2'h3
  } dmsl_op_t;
  // accumulator_select codes
  typedef enum logic [1:0] {
    SEL_HI = 2'h0,
    SEL_LO = 2'h1,
    SEL_OPND = 2'h2
  } dmsl_sel_t;
endpackage

// ---- rtl/dmsl_core.sv ----
// multiply-step, nop, invert and or datapath with an apb register port
// assumes an apb master on pclk; instructions issue by writing the command
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ns
module dmsl_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // architectural state
  logic [31:0] hi_q, hi_d; // upper accumulator
  logic [31:0] lo_q, lo_d; // lower accumulator
  logic [31:0] op_q, op_d; // multiplier operand
  logic [3:0] flg_q, flg_d; // carry, overflow, sign, zero
  logic [31:0] rd_q, rd_d; // registered read data
  logic rdy_q, rdy_d; // one-wait-state ready
  logic err_q, err_d; // unmapped access answer
  // decoded command
  logic wr_acc; // write completing this cycle
  dmsl_pkg::dmsl_op_t opc;
  dmsl_pkg::dmsl_sel_t s1, s2;
  logic [31:0] sum; // hi + gated operand; its carry out is dropped
  logic [31:0] src1, src2, res; // logic-op operands and result
  logic mapped;

  assign wr_acc = psel & penable & pwrite & rdy_q;
  assign opc = dmsl_pkg::dmsl_op_t'(pwdata[dmsl_pkg::CMD_OP_LSB +: 2]);
  assign s1 = dmsl_pkg::dmsl_sel_t'(pwdata[dmsl_pkg::CMD_SEL1_LSB +: 2]);
  assign s2 = dmsl_pkg::dmsl_sel_t'(pwdata[dmsl_pkg::CMD_SEL2_LSB +: 2]);

  // pick a register by accumulator_select; code 3 reads the operand
  function automatic logic [31:0] pick(input dmsl_pkg::dmsl_sel_t s,
    input logic [31:0] h, input logic [31:0] l, input logic [31:0] o);
    if (s == dmsl_pkg::SEL_HI) begin
      pick = h;
    end else if (s == dmsl_pkg::SEL_LO) begin
      pick = l;
    end else begin
      pick = o;
    end
  endfunction

  // datapath arithmetic: a 32-bit sum, so every multiply step clears hi[31];
  // limitation: products are exact only for operands below 2^31
  always_comb begin
    sum = hi_q + (lo_q[0] ? op_q : 32'h0000_0000);
    src1 = pick(s1, hi_q, lo_q, op_q);
    src2 = pick(s2, hi_q, lo_q, op_q);
    res = (opc == dmsl_pkg::OP_OR) ? (src1 | src2) : ~src1;
  end

  // address decode: only the five word offsets are mapped
  always_comb begin
    if (paddr == dmsl_pkg::OFF_ACC_HI) begin
      mapped = 1'b1;
    end else if (paddr == dmsl_pkg::OFF_ACC_LO) begin
      mapped = 1'b1;
    end else if (paddr == dmsl_pkg::OFF_OPND) begin
      mapped = 1'b1;
    end else if (paddr == dmsl_pkg::OFF_FLAGS) begin
      mapped = 1'b1;
    end else if (paddr == dmsl_pkg::OFF_CMD) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // next-state of registers and instruction execution
  always_comb begin
    hi_d = hi_q;
    lo_d = lo_q;
    op_d = op_q;
    flg_d = flg_q;
    if (wr_acc && mapped) begin
      if (paddr == dmsl_pkg::OFF_ACC_HI) begin
        hi_d = pwdata;
      end else if (paddr == dmsl_pkg::OFF_ACC_LO) begin
        lo_d = pwdata;
      end else if (paddr == dmsl_pkg::OFF_OPND) begin
        op_d = pwdata;
      end else if (paddr == dmsl_pkg::OFF_FLAGS) begin
        flg_d = pwdata[3:0];
      end else begin
        case (opc)
          dmsl_pkg::OP_MULT: begin
            // hi[30:0] takes sum bits 31:1; hi[31] is forced low
            hi_d = {1'b0, sum[31:1]};
            // lo[31] takes the low bit of the step's sum
            lo_d = {sum[0], lo_q[31:1]};
            // operand left alone
            flg_d[dmsl_pkg::FLG_S] = 1'b0;
            flg_d[dmsl_pkg::FLG_Z] = ({1'b0, sum[31:1]} == 32'h0000_0000);
          end
          dmsl_pkg::OP_NOT, dmsl_pkg::OP_OR: begin
            if (s1 == dmsl_pkg::SEL_HI) begin
              hi_d = res;
            end else if (s1 == dmsl_pkg::SEL_LO) begin
              lo_d = res;
            end else begin
              op_d = res;
            end
            flg_d[dmsl_pkg::FLG_C] = 1'b0;
            flg_d[dmsl_pkg::FLG_O] = 1'b0;
            flg_d[dmsl_pkg::FLG_S] = res[31];
            flg_d[dmsl_pkg::FLG_Z] = (res == 32'h0000_0000);
          end
          default: begin
            // nop leaves everything
          end
        endcase
      end
    end
  end

  // apb answer: one wait state, read data and error registered
  always_comb begin
    rdy_d = psel & penable & ~rdy_q;
    err_d = psel & penable & ~rdy_q & ~mapped;
    rd_d = rd_q;
    if (psel && penable && !rdy_q) begin
      if (pwrite || !mapped) begin
        rd_d = 32'h0000_0000;
      end else if (paddr == dmsl_pkg::OFF_ACC_HI) begin
        rd_d = hi_q;
      end else if (paddr == dmsl_pkg::OFF_ACC_LO) begin
        rd_d = lo_q;
      end else if (paddr == dmsl_pkg::OFF_OPND) begin
        rd_d = op_q;
      end else if (paddr == dmsl_pkg::OFF_FLAGS) begin
        rd_d = {28'h0000000, flg_q};
      end else begin
        rd_d = 32'h0000_0000;
      end
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q <= dmsl_pkg::RST_WORD;
      lo_q <= dmsl_pkg::RST_WORD;
      op_q <= dmsl_pkg::RST_WORD;
      flg_q <= dmsl_pkg::RST_FLAGS;
      rd_q <= dmsl_pkg::RST_WORD;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      op_q <= op_d;
      flg_q <= flg_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;

  // helpers for checks
  logic is_cmd;
  assign is_cmd = wr_acc && mapped && (paddr == dmsl_pkg::OFF_CMD);

  property p_mult_hi;
    @(posedge pclk) disable iff (!presetn)
    is_cmd && opc == dmsl_pkg::OP_MULT |=>
      hi_q == {1'b0, 31'(($past(hi_q) + ($past(lo_q[0]) ?
      $past(op_q) : 32'h0000_0000)) >> 1)};
  endproperty
  a_mult_hi: assert property (p_mult_hi)
    else $error("multiply step upper accumulator wrong");

  property p_mult_lo;
    @(posedge pclk) disable iff (!presetn)
    is_cmd && opc == dmsl_pkg::OP_MULT |=>
      lo_q[30:0] == $past(lo_q[31:1]) &&
      lo_q[31] == ($past(hi_q[0]) ^ ($past(op_q[0]) & $past(lo_q[0])));
  endproperty
  a_mult_lo: assert property (p_mult_lo)
    else $error("multiply step lower accumulator wrong");

  property p_mult_opnd;
    @(posedge pclk) disable iff (!presetn)
    is_cmd && opc == dmsl_pkg::OP_MULT |=> $stable(op_q);
  endproperty
  a_mult_opnd: assert property (p_mult_opnd)
    else $error("multiply step changed operand");

  property p_mult_co;
    @(posedge pclk) disable iff (!presetn)
    is_cmd && opc == dmsl_pkg::OP_MULT |=>
      $stable(flg_q[1:0]) && !flg_q[dmsl_pkg::FLG_S];
  endproperty
  a_mult_co: assert property (p_mult_co)
    else $error("multiply step touched carry or overflow");

  property p_nop;
    @(posedge pclk) disable iff (!presetn)
    is_cmd && opc == dmsl_pkg::OP_NOP |=>
      $stable(hi_q) && $stable(lo_q) && $stable(op_q) && $stable(flg_q);
  endproperty
  a_nop: assert property (p_nop)
    else $error("nop changed state");

  property p_not_hi;
    @(posedge pclk) disable iff (!presetn)
    is_cmd && opc == dmsl_pkg::OP_NOT && s1 == dmsl_pkg::SEL_HI |=>
      hi_q == ~$past(hi_q) && $stable(lo_q);
  endproperty
  a_not_hi: assert property (p_not_hi)
    else $error("invert of upper accumulator wrong");

  property p_or_lo;
    @(posedge pclk) disable iff (!presetn)
    is_cmd && opc == dmsl_pkg::OP_OR && s1 == dmsl_pkg::SEL_LO &&
      s2 == dmsl_pkg::SEL_OPND |=> lo_q == ($past(lo_q) | $past(op_q));
  endproperty
  a_or_lo: assert property (p_or_lo)
    else $error("or into lower accumulator wrong");

  property p_logic_flags;
    @(posedge pclk) disable iff (!presetn)
    is_cmd && (opc == dmsl_pkg::OP_NOT || opc == dmsl_pkg::OP_OR) |=>
      flg_q[1:0] == 2'h0 && flg_q[dmsl_pkg::FLG_Z] ==
      (pick($past(s1), hi_q, lo_q, op_q) == 32'h0000_0000) &&
      flg_q[dmsl_pkg::FLG_S] == pick($past(s1), hi_q, lo_q, op_q) >> 31;
  endproperty
  a_logic_flags: assert property (p_logic_flags)
    else $error("logic flags wrong");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("apb ready not a single pulse");

  c_mult: cover property (@(posedge pclk) is_cmd && opc == dmsl_pkg::OP_MULT);
  c_not: cover property (@(posedge pclk) is_cmd && opc == dmsl_pkg::OP_NOT);
  c_or: cover property (@(posedge pclk) is_cmd && opc == dmsl_pkg::OP_OR);
  c_err: cover property (@(posedge pclk) pslverr);
endmodule

// ---- verif/dmsl_host.sv ----
// apb master model standing in for the instruction sequencer
// assumes dmsl_core as the slave on the same pclk
`timescale 1ns/1ns
module dmsl_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // one whole transfer; nothing moves until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines change so a stale value is never mistaken for data
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ---- verif/dsp_multiply_step_and_logic_ops_test.sv ----
// self-checking bench: reference model, queued notes, output monitor
// assumes dmsl_core with one wait state on every apb transfer
`timescale 1ns/1ns
module dsp_multiply_step_and_logic_ops_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [33:0] notes [$]; // {read, slave error, data}
  logic [33:0] n;
  logic [31:0] h, l, o, seed, rd;
  logic [63:0] prod;
  logic [3:0] f; // model flags {z, s, o, c}
  logic [1:0] s1, s2;
  int failures = 0;
  int check_count = 0;
  always #5 pclk = ~pclk;
  dmsl_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dmsl_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // selects 2 and 3 both name the operand register
  function automatic logic [1:0] idx(input logic [1:0] s);
    return (s == 2'h3) ? 2'h2 : s;
  endfunction
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // oldest note is matched against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      n = (notes.size() > 0) ? notes.pop_front() : 34'h0;
      check("slave error", {31'h0, pslverr}, {31'h0, n[32]});
      if (n[33]) check("read data", prdata, n[31:0]);
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic err);
    notes.push_back({1'b0, err, 32'h0});
    u_host.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e,
                     input logic err);
    notes.push_back({1'b1, err, e});
    u_host.xfer(1'b0, a, 32'h0, rd);
  endtask
  task automatic regs();
    rdx(dmsl_pkg::OFF_ACC_HI, h, 1'b0);
    rdx(dmsl_pkg::OFF_ACC_LO, l, 1'b0);
    rdx(dmsl_pkg::OFF_OPND, o, 1'b0);
    rdx(dmsl_pkg::OFF_FLAGS, {28'h0, f}, 1'b0);
  endtask
  // model one instruction, then issue it
  task automatic issue(input logic [1:0] op, input logic [1:0] a,
                       input logic [1:0] b);
    logic [31:0] v [3];
    logic [32:0] sum;
    v[0] = h;
    v[1] = l;
    v[2] = o;
    if (op == 2'h1) begin
      sum = {1'b0, h} + {1'b0, l[0] ? o : 32'h0};
      l = {sum[0], l[31:1]};
      h = {1'b0, sum[31:1]};
      f[3:2] = {h == 32'h0, 1'b0};
    end else if (op != 2'h0) begin
      v[idx(a)] = (op == 2'h2) ? ~v[idx(a)] : v[idx(a)] | v[idx(b)];
      f = {v[idx(a)] == 32'h0, v[idx(a)][31], 2'b00};
      h = v[0];
      l = v[1];
      o = v[2];
    end
    wr(dmsl_pkg::OFF_CMD, {22'h0, b, 2'h0, a, 2'h0, op}, 1'b0);
  endtask
  // watchdog well past the expected run length
  initial begin
    repeat (6000) @(posedge pclk);
    failures++;
    wrap_up();
  end
  initial begin
    {h, l, o, f} = 100'h0;
    seed = 32'h3699;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    regs();
    wr(8'h14, seed, 1'b1);
    rdx(8'h14, 32'h0, 1'b1);
    rdx(dmsl_pkg::OFF_CMD, 32'h0, 1'b0);
    // full products; random flags show carry and overflow are kept
    for (int t = 0; t < 3; t++) begin
      seed = xs(seed);
      // the step drops the sum's carry: keep the operand below 2^31
      o = {1'b0, seed[30:0]};
      l = xs(seed);
      seed = xs(l);
      f = seed[3:0];
      h = 32'h0;
      prod = {32'h0, o} * {32'h0, l};
      wr(dmsl_pkg::OFF_OPND, o, 1'b0);
      wr(dmsl_pkg::OFF_ACC_LO, l, 1'b0);
      wr(dmsl_pkg::OFF_FLAGS, seed, 1'b0);
      wr(dmsl_pkg::OFF_ACC_HI, 32'h0, 1'b0);
      for (int k = 0; k < 32; k++) issue(2'h1, 2'h0, 2'h0);
      rdx(dmsl_pkg::OFF_ACC_HI, prod[63:32], 1'b0);
      rdx(dmsl_pkg::OFF_ACC_LO, prod[31:0], 1'b0);
      regs();
    end
    // random mix of all four opcodes and every select code
    for (int t = 0; t < 40; t++) begin
      seed = xs(seed);
      if (seed[20]) begin
        f = seed[3:0];
        l = xs(seed);
        wr(dmsl_pkg::OFF_FLAGS, seed, 1'b0);
        wr(dmsl_pkg::OFF_ACC_LO, l, 1'b0);
      end
      s1 = seed[5:4];
      s2 = seed[9:8];
      if (idx(s2) == idx(s1)) s2 = (idx(s1) == 2'h2) ? 2'h0 : s1 + 2'h1;
      issue(seed[1:0], s1, s2);
      regs();
    end
    // directed cases the random mix may miss
    issue(2'h3, 2'h1, 2'h2);
    issue(2'h2, 2'h0, 2'h0);
    regs();
    wrap_up();
  end
endmodule
